// ### rtl/sir_pkg.sv
package sir_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_GLOBAL_INGRESS = 14'h1840;
  localparam logic [13:0] IDX_PORT_INGRESS   = 14'h1841;
  localparam logic [13:0] IDX_TAGGED_ONLY    = 14'h1842;
  localparam logic [13:0] IDX_STP_STATE      = 14'h1843;
  localparam logic [13:0] IDX_NONMEMBER      = 14'h1850;
  localparam logic [13:0] IDX_DROP_COUNT     = 14'h1851;

  // ----------------------------------------------------------------
  // writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_GLOBAL     = 32'h0000_3fff;
  localparam logic [31:0] MASK_PORT       = 32'h0000_003f;
  localparam logic [31:0] MASK_PORT3      = 32'h0000_0007;
  localparam logic [31:0] MASK_STP        = 32'h0000_003f;
  localparam logic [13:0] RST_GLOBAL      = 14'h0006;
  localparam logic [5:0]  RST_PORT        = 6'h38;
  localparam logic [2:0]  RST_PORT3       = 3'h0;
  localparam logic [5:0]  RST_STP         = 6'h00;
  localparam logic [31:0] CNT_TEST_VALUE  = 32'h07ff_fffc;

  // ----------------------------------------------------------------
  // field positions of the global and port registers
  // ----------------------------------------------------------------
  localparam int G_ECHO      = 13;
  localparam int G_SNOOP_LO  = 10;
  localparam int G_USE_IP    = 9;
  localparam int G_MLD       = 8;
  localparam int G_IGMP      = 7;
  localparam int G_CNT_TEST  = 6;
  localparam int G_DA_PRI    = 5;
  localparam int G_FILT_MC   = 4;
  localparam int G_DROP_UNK  = 3;
  localparam int G_PREC      = 2;
  localparam int G_VLAN_PRI  = 1;
  localparam int G_VLAN_EN   = 0;
  localparam int P_LEARN_LO  = 3;

  // spanning-tree codes
  localparam logic [1:0] STP_FORWARDING = 2'h0;
  localparam logic [1:0] STP_BLOCKING   = 2'h1;
  localparam logic [1:0] STP_LEARNING   = 2'h2;
  localparam logic [1:0] STP_LISTENING  = 2'h3;

  localparam logic [2:0] ALL_PORTS = 3'h7;

  typedef enum logic {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } sir_bus_type;

  // packet header facts handed in by the parser and address table
  typedef struct packed {
    logic [1:0] port;          // ingress port 0..2
    logic       has_tag;       // any 802.1Q tag present
    logic       vid_nonzero;   // tag carries a real VLAN id
    logic [2:0] vlan_pri;
    logic [2:0] vlan_members;
    logic       is_ipv4;
    logic       is_ipv6;
    logic [7:0] ip_tos;        // TOS or SC octet
    logic [2:0] diffserv_pri;  // table result for this TOS
    logic       is_igmp;
    logic       is_mld;
    logic       da_multicast;
    logic       da_broadcast;
    logic       da_found;
    logic       da_static;
    logic [2:0] da_pri;
    logic [2:0] da_ports;
    logic [2:0] default_pri;
  } sir_pkt_type;

  typedef struct packed {
    logic [2:0] dest_ports;
    logic       drop;
    logic       learn;
    logic       snooped;
    logic [2:0] prio;          // chosen transmit priority
  } sir_dec_type;

endpackage

// ### rtl/sir_ingress.sv
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// register map, index is the byte address over four
// ----------------------------------------------------------------
// global ingress config, index 0x1840, bits 13:0
//   13     snoop echo back to the source port
//   12:10  snoop destination bitmap, ports 2..0
//   9      ip tos or sc as a priority source
//   8      mld snoop, 7 igmp snoop
//   6      counter test load on read
//   5      static table entry priority first
//   4      unknown multicast drop, 3 unknown unicast drop
//   2      tos precedence rather than diffserv map
//   1      vlan tag priority ahead of ip, 0 vlan rules on
// port ingress config, index 0x1841
//   5:3    learning enable, ports 2..0
//   2:0    membership check, ports 2..0
// tagged-only admit, index 0x1842, bits 2:0, ports 2..0
// spanning-tree state, index 0x1843, two bits per port, port 0 lowest
//   codes 00 forwarding, 01 blocking, 10 learning, 11 listening
//   only forwarding and learning let a port learn
// nonmember admit, index 0x1850, bits 2:0, ports 2..0
// drop counter, index 0x1851, read only, cleared or loaded by a read
// reset: global 0x0006, port 0x38, all others zero
// ----------------------------------------------------------------
// interface timing
// ----------------------------------------------------------------
// bus request taken on an idle edge, answered one cycle later
// waitrequest low for exactly one cycle; two cycles per access
// read data captured at the taking edge, stands until the next access; a write zeroes it
// unmapped indices read zero and swallow writes
// byte enables gate writes lane by lane
// one header summary in and one decision out per cycle, in order
// ready falls only with both buffer entries full, so no word is lost
// a header sees the registers as they stand at its taking edge
// limitation: table lookup, diffserv map and vlan membership arrive
// ready-made in the header summary; this block only decides
// port index 3 escapes every per-port rule and never learns
module sir_ingress
  import sir_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [15:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        PKT_IN_VALID,
  input  wire sir_pkt_type PKT_IN,
  output logic             PKT_IN_READY,
  output logic             DEC_OUT_VALID,
  output sir_dec_type      DEC_OUT,
  input  wire logic        DEC_OUT_READY
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // all state in one struct, registered by one process
  typedef struct packed {
    sir_bus_type bus;
    logic [31:0] rdata;
    logic [13:0] global_cfg;
    logic [5:0]  port_cfg;
    logic [2:0]  tagged_only;
    logic [5:0]  stp_state;
    logic [2:0]  nonmember;
    logic [31:0] drop_count;
    logic        out_valid;
    sir_dec_type out_data;
    logic        skid_valid;
    sir_dec_type skid_data;
    logic        waitreq;     // pin copy, kept as its own flop
    logic        in_ready;    // pin copy, kept as its own flop
  } sir_state_type;

  sir_state_type st_q;
  sir_state_type st_d;

  logic [31:0] be_mask;
  logic [13:0] idx;
  logic [31:0] rd_value;
  logic        hit;
  logic        accept;
  logic        in_take;
  sir_dec_type dec;
  logic [2:0]  in_bit;
  logic        vlan_en;
  logic        snoop;
  logic        mem_chk;
  logic        drop_any;
  logic        ip_ok;
  logic        vlan_ok;
  logic [1:0]  port_stp;

  assign idx     = AVS_ADDRESS[15:2];
  assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  // unmapped indices answer zero; upper bits of narrow registers zero
  // the counter reads its live value; the clear is in the next-state logic
  always_comb begin
    rd_value = 32'h0;
    hit      = 1'b1;
    if (idx == IDX_GLOBAL_INGRESS) begin
      rd_value = {18'h0, st_q.global_cfg};
    end else if (idx == IDX_PORT_INGRESS) begin
      rd_value = {26'h0, st_q.port_cfg};
    end else if (idx == IDX_TAGGED_ONLY) begin
      rd_value = {29'h0, st_q.tagged_only};
    end else if (idx == IDX_STP_STATE) begin
      rd_value = {26'h0, st_q.stp_state};
    end else if (idx == IDX_NONMEMBER) begin
      rd_value = {29'h0, st_q.nonmember};
    end else if (idx == IDX_DROP_COUNT) begin
      rd_value = st_q.drop_count;
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // ingress decision on the packet at the input
  // ----------------------------------------------------------------
  // filters, any one of which drops:
  //   tagged-only admit, ingress membership, egress membership,
  //   unknown multicast (snooped and broadcast exempt), unknown unicast
  // destination: snoop bitmap, else table ports, else flood
  // priority: static table entry, vlan tag, ip, port default
  // hazard: filters read the registers at the taking edge, so a
  // mid-stream write only affects headers taken after it lands
  // purely combinational; the buffer below registers the result
  always_comb begin
    in_bit   = 3'h1 << PKT_IN.port;
    vlan_en  = st_q.global_cfg[G_VLAN_EN];
    snoop    = (st_q.global_cfg[G_MLD] & PKT_IN.is_mld)
             | (st_q.global_cfg[G_IGMP] & PKT_IN.is_igmp);
    // per-port filters stay dormant unless VLAN rules are on
    mem_chk  = vlan_en & |(st_q.port_cfg[2:0] & in_bit);
    // any one filter is enough to drop
    drop_any = 1'b0;
    // untagged and priority-tagged frames share a zero vlan id
    if (vlan_en && |(st_q.tagged_only & in_bit) && !PKT_IN.vid_nonzero) begin
      drop_any = 1'b1;
    end
    // ingress membership, waived per port by nonmember admit
    if (mem_chk && !(|(PKT_IN.vlan_members & in_bit))
        && !(|(st_q.nonmember & in_bit))) begin
      drop_any = 1'b1;
    end
    // known destinations need every egress port in the vlan;
    // unknown ones rely on the ingress check alone
    if (mem_chk && PKT_IN.da_found
        && |(PKT_IN.da_ports & ~PKT_IN.vlan_members)) begin
      drop_any = 1'b1;
    end
    // snooped control traffic is never filtered as unknown multicast
    if (st_q.global_cfg[G_FILT_MC] && PKT_IN.da_multicast && !PKT_IN.da_broadcast
        && !PKT_IN.da_found && !snoop) begin
      drop_any = 1'b1;
    end
    // broadcast counts as multicast here, so it never hits this filter
    if (st_q.global_cfg[G_DROP_UNK] && !PKT_IN.da_multicast && !PKT_IN.da_found) begin
      drop_any = 1'b1;
    end

    // destination: snoop ports, table ports, or flood
    if (snoop) begin
      dec.dest_ports = st_q.global_cfg[G_SNOOP_LO +: 3];
    end else if (PKT_IN.da_found) begin
      dec.dest_ports = PKT_IN.da_ports;
    end else begin
      dec.dest_ports = ALL_PORTS;
    end
    // source port stripped unless a snooped frame may echo
    if (!(snoop && st_q.global_cfg[G_ECHO])) begin
      dec.dest_ports = dec.dest_ports & ~in_bit;
    end
    // a dropped frame goes nowhere but still reports learning
    if (drop_any) begin
      dec.dest_ports = 3'h0;
    end
    dec.drop    = drop_any;
    dec.snooped = snoop;

    // learning gated by port enable and spanning-tree state
    // port 3 reads past the state field; its enable bit is zero anyway
    // blocking and listening ports never learn
    port_stp  = st_q.stp_state[{PKT_IN.port, 1'b0} +: 2];
    dec.learn = |(st_q.port_cfg[P_LEARN_LO +: 3] & in_bit)
              & ((port_stp == STP_FORWARDING) | (port_stp == STP_LEARNING));

    // priority source order: static DA, VLAN, IP, port default
    ip_ok   = st_q.global_cfg[G_USE_IP] & (PKT_IN.is_ipv4 | PKT_IN.is_ipv6);
    vlan_ok = vlan_en & PKT_IN.has_tag;
    // a static entry wins even over a tagged frame
    // vlan tag yields to ip only when bit 1 is clear and ip is usable
    // ipv6 has no diffserv path here: always the top three sc bits
    if (st_q.global_cfg[G_DA_PRI] && PKT_IN.da_found && PKT_IN.da_static) begin
      dec.prio = PKT_IN.da_pri;
    end else if (vlan_ok && (st_q.global_cfg[G_VLAN_PRI] || !ip_ok)) begin
      dec.prio = PKT_IN.vlan_pri;
    end else if (ip_ok && PKT_IN.is_ipv4 && !st_q.global_cfg[G_PREC]) begin
      dec.prio = PKT_IN.diffserv_pri;
    end else if (ip_ok) begin
      dec.prio = PKT_IN.ip_tos[7:5];
    end else begin
      dec.prio = PKT_IN.default_pri;
    end
  end

  // ----------------------------------------------------------------
  // next state: bus slave, registers, two-entry output buffer
  // ----------------------------------------------------------------
  // one-deep bus slave: nothing inside waits, so the answer is always
  // exactly one cycle behind the request
  assign accept  = (st_q.bus == BUS_ANSWER);
  assign in_take = PKT_IN_VALID & ~st_q.skid_valid;

  always_comb begin
    st_d = st_q;
    // request held one cycle, answered the next with waitrequest low
    case (st_q.bus)
      BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          st_d.bus   = BUS_ANSWER;
          st_d.rdata = AVS_READ ? rd_value : 32'h0;
        end
      end
      BUS_ANSWER: begin
        st_d.bus = BUS_IDLE;
      end
      default: begin
        st_d.bus = BUS_IDLE;
      end
    endcase

    // waitrequest follows the next bus state so the pin comes from a flop
    st_d.waitreq = (st_d.bus != BUS_ANSWER);

    // drop counter: cleared or test-loaded at the edge that captures it,
    // so no drop slips in between capture and answer; a drop in the
    // same cycle adds on top of the new value
    if (!accept && AVS_READ && hit && idx == IDX_DROP_COUNT) begin
      st_d.drop_count = st_q.global_cfg[G_CNT_TEST] ? CNT_TEST_VALUE : 32'h0;
    end
    if (in_take && dec.drop) begin
      st_d.drop_count = st_d.drop_count + 32'h1;
    end

    // writes take effect at the edge where waitrequest is low
    // the counter and unmapped indices swallow writes
    if (accept && AVS_WRITE) begin
      if (idx == IDX_GLOBAL_INGRESS) begin
        st_d.global_cfg = 14'((({18'h0, st_q.global_cfg} & ~(be_mask & MASK_GLOBAL))
                        | (AVS_WRITEDATA & be_mask & MASK_GLOBAL)));
      end else if (idx == IDX_PORT_INGRESS) begin
        st_d.port_cfg = 6'((({26'h0, st_q.port_cfg} & ~(be_mask & MASK_PORT))
                      | (AVS_WRITEDATA & be_mask & MASK_PORT)));
      end else if (idx == IDX_TAGGED_ONLY) begin
        st_d.tagged_only = 3'((({29'h0, st_q.tagged_only} & ~(be_mask & MASK_PORT3))
                         | (AVS_WRITEDATA & be_mask & MASK_PORT3)));
      end else if (idx == IDX_STP_STATE) begin
        st_d.stp_state = 6'((({26'h0, st_q.stp_state} & ~(be_mask & MASK_STP))
                       | (AVS_WRITEDATA & be_mask & MASK_STP)));
      end else if (idx == IDX_NONMEMBER) begin
        st_d.nonmember = 3'((({29'h0, st_q.nonmember} & ~(be_mask & MASK_PORT3))
                       | (AVS_WRITEDATA & be_mask & MASK_PORT3)));
      end
    end

    // output register drains first; skid catches the word in flight
    // the skid entry only fills while the output is stalled and empties
    // first when the consumer resumes, so order is kept
    if (DEC_OUT_READY || !st_q.out_valid) begin
      if (st_q.skid_valid) begin
        st_d.out_valid  = 1'b1;
        st_d.out_data   = st_q.skid_data;
        st_d.skid_valid = 1'b0;
      end else begin
        st_d.out_valid = PKT_IN_VALID;
        st_d.out_data  = dec;
      end
    end else if (in_take) begin
      st_d.skid_valid = 1'b1;
      st_d.skid_data  = dec;
    end

    // room for one more word while the skid entry is free
    st_d.in_ready = ~st_d.skid_valid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_q             <= '0;
      st_q.bus         <= BUS_IDLE;
      st_q.global_cfg  <= RST_GLOBAL;
      st_q.port_cfg    <= RST_PORT;
      st_q.tagged_only <= RST_PORT3;
      st_q.stp_state   <= RST_STP;
      st_q.waitreq     <= 1'b1;
      st_q.in_ready    <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops
  // waitrequest and ready have their own flops rather than gates
  assign AVS_READDATA    = st_q.rdata;
  assign AVS_WAITREQUEST = st_q.waitreq;
  assign PKT_IN_READY    = st_q.in_ready;   // high while the skid entry is empty
  assign DEC_OUT_VALID   = st_q.out_valid;
  assign DEC_OUT         = st_q.out_data;

endmodule

// ### verif/sir_ingress_checker.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port-level checks of bus answers and decisions
// ----------------------------------------------------------------
module sir_ingress_checker
  import sir_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        PKT_IN_VALID,
  input wire sir_pkt_type PKT_IN,
  input wire logic        PKT_IN_READY,
  input wire logic        DEC_OUT_VALID,
  input wire sir_dec_type DEC_OUT,
  input wire logic        DEC_OUT_READY
);
  logic [13:0] glob_q;
  wire         rd_ans = AVS_READ && !AVS_WAITREQUEST;
  wire  [13:0] idx    = AVS_ADDRESS[15:2];

  // shadow of the global register; byte lanes ignored, bench writes whole words
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      glob_q <= RST_GLOBAL;
    end else if (AVS_WRITE && !AVS_WAITREQUEST && idx == IDX_GLOBAL_INGRESS) begin
      glob_q <= AVS_WRITEDATA[13:0];
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  property p_answer; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after request");
  property p_single; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  a_single: assert property (p_single) else $error("answer longer than one cycle");
  property p_rsv_glob; rd_ans && idx == IDX_GLOBAL_INGRESS |-> AVS_READDATA[31:14] == '0; endproperty
  a_rsv_glob: assert property (p_rsv_glob) else $error("global reserved bits set");
  property p_rsv_port; rd_ans && idx == IDX_PORT_INGRESS |-> AVS_READDATA[31:6] == '0; endproperty
  a_rsv_port: assert property (p_rsv_port) else $error("port reserved bits set");
  property p_rsv_tag; rd_ans && idx == IDX_TAGGED_ONLY |-> AVS_READDATA[31:3] == '0; endproperty
  a_rsv_tag: assert property (p_rsv_tag) else $error("tagged reserved bits set");
  property p_drop; DEC_OUT_VALID && DEC_OUT.drop |-> DEC_OUT.dest_ports == 3'h0; endproperty
  a_drop: assert property (p_drop) else $error("dropped packet has ports");
  property p_hold; DEC_OUT_VALID && !DEC_OUT_READY |=> DEC_OUT_VALID && $stable(DEC_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("decision changed while stalled");
  property p_echo;
    DEC_OUT_VALID && DEC_OUT.snooped && !DEC_OUT.drop && glob_q[G_ECHO]
      |-> DEC_OUT.dest_ports == glob_q[12:10];
  endproperty
  a_echo: assert property (p_echo) else $error("echoed snoop ports wrong");
  property p_snoop_en; DEC_OUT_VALID && DEC_OUT.snooped |-> glob_q[G_MLD] || glob_q[G_IGMP];
  endproperty
  a_snoop_en: assert property (p_snoop_en) else $error("snooped while disabled");
  // a full skid only arises behind a full output stage
  property p_skid; !PKT_IN_READY |-> DEC_OUT_VALID; endproperty
  a_skid: assert property (p_skid) else $error("input stalled with empty output");
endmodule

bind sir_ingress sir_ingress_checker chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .PKT_IN_VALID(PKT_IN_VALID), .PKT_IN(PKT_IN), .PKT_IN_READY(PKT_IN_READY),
  .DEC_OUT_VALID(DEC_OUT_VALID), .DEC_OUT(DEC_OUT), .DEC_OUT_READY(DEC_OUT_READY));

// ### verif/test_sir_ingress.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module test_sir_ingress
  import sir_pkg::*;
;
  logic        CLOCK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic        PKT_IN_VALID, PKT_IN_READY, DEC_OUT_VALID, DEC_OUT_READY;
  logic [15:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rdat;
  logic [3:0]  AVS_BYTEENABLE;
  sir_pkt_type PKT_IN, p, base;
  sir_dec_type DEC_OUT;
  int          num_errors, n_tests, cyc;
  logic [13:0] ridx [3] = '{IDX_GLOBAL_INGRESS, IDX_PORT_INGRESS, IDX_TAGGED_ONLY};
  logic [31:0] rrst [3] = '{32'h6, 32'h38, 32'h0};
  logic [31:0] rmsk [3] = '{32'h3fff, 32'h3f, 32'h7};

  sir_ingress uut (
    .CLOCK(CLOCK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PKT_IN_VALID(PKT_IN_VALID), .PKT_IN(PKT_IN), .PKT_IN_READY(PKT_IN_READY),
    .DEC_OUT_VALID(DEC_OUT_VALID), .DEC_OUT(DEC_OUT), .DEC_OUT_READY(DEC_OUT_READY));

  // ----------------------------------------------------------------
  // bus and stream tasks
  // ----------------------------------------------------------------
  // idle edge after release keeps strobes from being set twice in a step
  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    AVS_ADDRESS <= {i, 2'b00};
    AVS_WRITEDATA <= d;
    AVS_WRITE <= 1'b1;
    do @(posedge CLOCK); while (AVS_WAITREQUEST);
    AVS_WRITE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic rd(input logic [13:0] i);
    AVS_ADDRESS <= {i, 2'b00};
    AVS_READ <= 1'b1;
    do @(posedge CLOCK); while (AVS_WAITREQUEST);
    rdat = AVS_READDATA;
    AVS_READ <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic g(input logic [31:0] d);
    wr(IDX_GLOBAL_INGRESS, d);
  endtask
  task automatic push(input sir_pkt_type v);
    PKT_IN <= v;
    PKT_IN_VALID <= 1'b1;
    do @(posedge CLOCK); while (!PKT_IN_READY);
  endtask
  task automatic pop(input sir_dec_type e);
    PKT_IN_VALID <= 1'b0;
    do @(posedge CLOCK); while (!DEC_OUT_VALID);
    `CHECK(DEC_OUT, e)
  endtask
  // fl packs drop, learn and snooped
  task automatic xfer(input logic [2:0] d, input logic [2:0] fl, input logic [2:0] pr);
    push(p);
    pop({d, fl, pr});
  endtask
  task automatic tend(input string s);
    $display("test %s done, errors so far %0d", s, num_errors);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, timeout and test sequence
  // ----------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  // whole run needs well under a thousand cycles
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      end_of_test();
    end
  end
  initial begin
    {RST_N, AVS_READ, AVS_WRITE, PKT_IN_VALID, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    AVS_BYTEENABLE = 4'hf;
    DEC_OUT_READY = 1'b1;
    base = '{port: 2'h1, vlan_pri: 3'h7, vlan_members: 3'h7, is_ipv4: 1'b1, ip_tos: 8'ha0,
             diffserv_pri: 3'h3, da_found: 1'b1, da_static: 1'b1, da_pri: 3'h6,
             da_ports: 3'h5, default_pri: 3'h2, default: '0};
    PKT_IN = base;
    repeat (4) @(posedge CLOCK);
    RST_N <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(ridx[i]);
      `CHECK(rdat, rrst[i])
      wr(ridx[i], 32'hffff_ffff);
      rd(ridx[i]);
      `CHECK(rdat, rmsk[i])
      wr(ridx[i], rrst[i]);
    end
    rd(14'h1844);
    `CHECK(rdat, 32'h0)
    AVS_BYTEENABLE <= 4'he;
    wr(IDX_PORT_INGRESS, 32'hffff_ffff);
    AVS_BYTEENABLE <= 4'hf;
    rd(IDX_PORT_INGRESS);
    `CHECK(rdat, 32'h38)
    wr(IDX_STP_STATE, 32'hffff_ffff);
    rd(IDX_STP_STATE);
    `CHECK(rdat, 32'h3f)
    wr(IDX_STP_STATE, 32'h0);
    tend("registers");
    p = base;
    g(32'h0);
    xfer(3'h5, 3'b010, 3'h2);
    g(32'h200);
    xfer(3'h5, 3'b010, 3'h3);
    g(32'h204);
    xfer(3'h5, 3'b010, 3'h5);
    g(32'h224);
    xfer(3'h5, 3'b010, 3'h6);
    p.da_static = 1'b0;
    xfer(3'h5, 3'b010, 3'h5);
    p = base;
    p.has_tag = 1'b1;
    p.vid_nonzero = 1'b1;
    g(32'h207);
    xfer(3'h5, 3'b010, 3'h7);
    g(32'h205);
    xfer(3'h5, 3'b010, 3'h5);
    g(32'h3);
    xfer(3'h5, 3'b010, 3'h7);
    g(32'h2);
    xfer(3'h5, 3'b010, 3'h2);
    tend("priority");
    p = base;
    p.da_found = 1'b0;
    g(32'h0);
    xfer(3'h5, 3'b010, 3'h2);
    g(32'h8);
    xfer(3'h0, 3'b110, 3'h2);
    p.da_multicast = 1'b1;
    g(32'h10);
    xfer(3'h0, 3'b110, 3'h2);
    p.da_broadcast = 1'b1;
    xfer(3'h5, 3'b010, 3'h2);
    tend("filters");
    p = base;
    p.da_ports = 3'h7;
    g(32'h0);
    xfer(3'h5, 3'b010, 3'h2);
    p = base;
    p.is_igmp = 1'b1;
    g(32'hc80);
    xfer(3'h1, 3'b011, 3'h2);
    g(32'h2c80);
    xfer(3'h3, 3'b011, 3'h2);
    g(32'hc00);
    xfer(3'h5, 3'b010, 3'h2);
    p = base;
    {p.is_ipv4, p.is_ipv6, p.is_mld} = 3'b011;
    g(32'h1900);
    xfer(3'h4, 3'b011, 3'h2);
    tend("snoop");
    p = base;
    g(32'h0);
    wr(IDX_PORT_INGRESS, 32'h28);
    xfer(3'h5, 3'b000, 3'h2);
    wr(IDX_PORT_INGRESS, 32'h38);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_STP_STATE, 32'(i) << 2);
      xfer(3'h5, {1'b0, ~i[0], 1'b0}, 3'h2);
    end
    wr(IDX_STP_STATE, 32'h0);
    tend("learning");
    wr(IDX_PORT_INGRESS, 32'h3a);
    g(32'h1);
    p.vlan_members = 3'h5;
    xfer(3'h0, 3'b110, 3'h2);
    wr(IDX_NONMEMBER, 32'h2);
    xfer(3'h5, 3'b010, 3'h2);
    wr(IDX_NONMEMBER, 32'h0);
    p.vlan_members = 3'h3;
    xfer(3'h0, 3'b110, 3'h2);
    p.da_found = 1'b0;
    xfer(3'h5, 3'b010, 3'h2);
    p.da_found = 1'b1;
    p.vlan_members = 3'h1;
    g(32'h0);
    xfer(3'h5, 3'b010, 3'h2);
    wr(IDX_PORT_INGRESS, 32'h38);
    p = base;
    wr(IDX_TAGGED_ONLY, 32'h2);
    g(32'h1);
    xfer(3'h0, 3'b110, 3'h2);
    p.has_tag = 1'b1;
    xfer(3'h0, 3'b110, 3'h7);
    p.vid_nonzero = 1'b1;
    xfer(3'h5, 3'b010, 3'h7);
    p = base;
    g(32'h0);
    xfer(3'h5, 3'b010, 3'h2);
    wr(IDX_TAGGED_ONLY, 32'h0);
    tend("vlan");
    rd(IDX_DROP_COUNT);
    rd(IDX_DROP_COUNT);
    `CHECK(rdat, 32'h0)
    g(32'h40);
    rd(IDX_DROP_COUNT);
    rd(IDX_DROP_COUNT);
    `CHECK(rdat, 32'h07ff_fffc)
    g(32'h0);
    tend("counter");
    // stalled receiver: second word parks in the skid entry
    DEC_OUT_READY <= 1'b0;
    push(p);
    p.default_pri = 3'h4;
    push(p);
    PKT_IN_VALID <= 1'b0;
    @(posedge CLOCK);
    `CHECK(PKT_IN_READY, 1'b0)
    DEC_OUT_READY <= 1'b1;
    pop('{3'h5, 1'b0, 1'b1, 1'b0, 3'h2});
    pop('{3'h5, 1'b0, 1'b1, 1'b0, 3'h4});
    tend("stall");
    end_of_test();
  end
endmodule
